// ==== tcc_dual_timer.sv ====
// two timer/counters with clock outputs behind an APB register slave
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_dual_timer (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [`TCC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  timerACountPin,
	input  wire logic                  timerBCountPin,
	input  wire logic                  timerAGatePinN,
	input  wire logic                  timerBGatePinN,
	input  wire logic                  timerAVectorAck,
	input  wire logic                  timerBVectorAck,
	output logic                       timerAIrq,
	output logic                       timerBIrq,
	output logic                       timerBOverflowPulse,
	output logic                       timerAClkoutPin,
	output logic                       timerBClkoutPin
);
	import tcc_pkg::*;

	tcc_state_t st_reg;
	tcc_state_t st_next;

	logic        preTick;
	logic        evIncA;
	logic        evIncB;
	logic        rateA;
	logic        rateB;
	logic        ctA;
	logic        ctB;
	logic        gateA;
	logic        gateB;
	logic        koModeA;
	logic        koModeB;
	tcc_mode_t   modeA;
	tcc_mode_t   modeB;
	logic        splitA;
	logic        frozenB;
	logic        stepA;
	logic        stepB;
	logic        stepH;
	logic [16:0] resA;
	logic [16:0] resB;
	logic        ovfA;
	logic        ovfB;
	logic        ovfH;
	logic        setFlagB;
	logic        busCommit;
	logic        wrEn;
	logic        wrCtrl;
	logic        wrMode;
	logic        wrTla;
	logic        wrTlb;
	logic        wrTha;
	logic        wrThb;
	logic        wrAux;

	function automatic logic isReg(input logic [`TCC_ADDR_W-1:0] a, input logic [9:0] idx);
		isReg = (a == {idx, 2'b00});
	endfunction

	// returns {overflow, high byte, low byte} after one count step
	function automatic logic [16:0] stepCount(input tcc_mode_t m, input logic [7:0] lo, input logic [7:0] hi);
		logic [12:0] c13;
		logic [15:0] c16;
		c13 = {hi, lo[`TCC_M0_LOW_MSB:0]} + 13'h0001;
		c16 = {hi, lo} + 16'h0001;
		case (m)
			TCC_MODE_13: begin
				// upper three low-byte bits take no part in the count
				stepCount = {({hi, lo[`TCC_M0_LOW_MSB:0]} == `TCC_M0_ONES), c13[12:5], lo[7:5],
					c13[`TCC_M0_LOW_MSB:0]};
			end
			TCC_MODE_16: begin
				stepCount = {({hi, lo} == `TCC_M1_ONES), c16};
			end
			TCC_MODE_RELOAD: begin
				if (lo == `TCC_BYTE_ONES) begin
					stepCount = {1'b1, hi, hi};
				end else begin
					stepCount = {1'b0, hi, lo + 8'h01};
				end
			end
			default: begin
				stepCount = {(lo == `TCC_BYTE_ONES), hi, lo + 8'h01};
			end
		endcase
	endfunction

	tcc_prescale #(
		.DIV(`TCC_PRESCALE)
	) uPrescale (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.tick    (preTick)
	);

	tcc_event_detect uEventA (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.sampleEn(rateA),
		.countPin(timerACountPin),
		.incr    (evIncA)
	);

	tcc_event_detect uEventB (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.sampleEn(rateB),
		.countPin(timerBCountPin),
		.incr    (evIncB)
	);

	assign rateA = st_reg.aux[`TCC_AUX_X12A] | preTick;
	assign rateB = st_reg.aux[`TCC_AUX_X12B] | preTick;
	assign ctA = st_reg.modeSel[`TCC_MODE_CT];
	assign ctB = st_reg.modeSel[`TCC_NIB_B+`TCC_MODE_CT];
	assign gateA = st_reg.modeSel[`TCC_MODE_GATE];
	assign gateB = st_reg.modeSel[`TCC_NIB_B+`TCC_MODE_GATE];
	assign modeA = tcc_mode_t'(st_reg.modeSel[`TCC_MODE_HI:`TCC_MODE_LO]);
	assign modeB = tcc_mode_t'(st_reg.modeSel[`TCC_NIB_B+`TCC_MODE_HI:`TCC_NIB_B+`TCC_MODE_LO]);
	assign koModeA = st_reg.aux[`TCC_AUX_KOA] & ~ctA;
	assign koModeB = st_reg.aux[`TCC_AUX_KOB] & ~ctB;
	assign splitA = (modeA == TCC_MODE_SPLIT) & ~koModeA;
	assign frozenB = (modeB == TCC_MODE_SPLIT) & ~koModeB;

	// counter mode advances on a detected fall, timer mode on the rate tick
	assign stepA = st_reg.ctrl[`TCC_CTRL_TRA] & (~gateA | timerAGatePinN) & (ctA ? evIncA : rateA);
	assign stepB = st_reg.ctrl[`TCC_CTRL_TRB] & (~gateB | timerBGatePinN) & (ctB ? evIncB : rateB)
		& ~frozenB;
	// the split high byte never counts events and ignores the gate
	assign stepH = splitA & st_reg.ctrl[`TCC_CTRL_TRB] & rateA;

	assign resA = stepCount(koModeA ? TCC_MODE_RELOAD : modeA, st_reg.tla, st_reg.tha);
	assign resB = stepCount(koModeB ? TCC_MODE_RELOAD : modeB, st_reg.tlb, st_reg.thb);
	assign ovfA = stepA & resA[16];
	assign ovfB = stepB & resB[16];
	assign ovfH = stepH & (st_reg.tha == `TCC_BYTE_ONES);
	// while A is split, B still overflows for the baud rate but owns no flag
	assign setFlagB = ovfH | (ovfB & ~splitA);

	assign busCommit = psel & penable & st_reg.pready;
	assign wrEn = busCommit & pwrite;
	assign wrCtrl = wrEn & isReg(paddr, `TCC_IDX_CTRL);
	assign wrMode = wrEn & isReg(paddr, `TCC_IDX_MODE);
	assign wrTla = wrEn & isReg(paddr, `TCC_IDX_TLA);
	assign wrTlb = wrEn & isReg(paddr, `TCC_IDX_TLB);
	assign wrTha = wrEn & isReg(paddr, `TCC_IDX_THA);
	assign wrThb = wrEn & isReg(paddr, `TCC_IDX_THB);
	assign wrAux = wrEn & isReg(paddr, `TCC_IDX_AUX);

	always_comb begin
		st_next = st_reg;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;

		if (stepA) begin
			st_next.tla = resA[7:0];
			st_next.tha = resA[15:8];
		end
		if (stepH) begin
			st_next.tha = st_reg.tha + 8'h01;
		end
		if (stepB) begin
			st_next.tlb = resB[7:0];
			st_next.thb = resB[15:8];
		end

		// a software write to a count byte wins over the count step
		if (wrTla) begin
			st_next.tla = pwdata[7:0];
		end
		if (wrTha) begin
			st_next.tha = pwdata[7:0];
		end
		if (wrTlb) begin
			st_next.tlb = pwdata[7:0];
		end
		if (wrThb) begin
			st_next.thb = pwdata[7:0];
		end
		if (wrMode) begin
			st_next.modeSel = pwdata[7:0];
		end
		if (wrAux) begin
			st_next.aux = pwdata[7:0];
		end
		if (wrCtrl) begin
			st_next.ctrl = pwdata[7:0];
		end

		// hardware set beats a software or vector clear in the same cycle
		st_next.ctrl[`TCC_CTRL_TFA] = ovfA | (wrCtrl ? pwdata[`TCC_CTRL_TFA]
			: st_reg.ctrl[`TCC_CTRL_TFA] & ~timerAVectorAck);
		st_next.ctrl[`TCC_CTRL_TFB] = setFlagB | (wrCtrl ? pwdata[`TCC_CTRL_TFB]
			: st_reg.ctrl[`TCC_CTRL_TFB] & ~timerBVectorAck);

		// one toggle per overflow gives 50% duty; disabled pin rests low
		st_next.koA = st_reg.aux[`TCC_AUX_KOA] & (st_reg.koA ^ (koModeA & ovfA));
		st_next.koB = st_reg.aux[`TCC_AUX_KOB] & (st_reg.koB ^ (koModeB & ovfB));

		st_next.irqA = st_reg.ctrl[`TCC_CTRL_TFA] & ~koModeA;
		st_next.irqB = st_reg.ctrl[`TCC_CTRL_TFB] & (splitA | ~koModeB);
		st_next.bOvf = ovfB;

		// one wait state: data are latched while pready is still low
		if (psel && penable && !st_reg.pready) begin
			st_next.pready = 1'b1;
			st_next.prdata = `TCC_RST_WORD;
			case (paddr)
				{`TCC_IDX_CTRL, 2'b00}: st_next.prdata[7:0] = st_reg.ctrl;
				{`TCC_IDX_MODE, 2'b00}: st_next.prdata[7:0] = st_reg.modeSel;
				{`TCC_IDX_TLA, 2'b00}: st_next.prdata[7:0] = st_reg.tla;
				{`TCC_IDX_TLB, 2'b00}: st_next.prdata[7:0] = st_reg.tlb;
				{`TCC_IDX_THA, 2'b00}: st_next.prdata[7:0] = st_reg.tha;
				{`TCC_IDX_THB, 2'b00}: st_next.prdata[7:0] = st_reg.thb;
				{`TCC_IDX_AUX, 2'b00}: st_next.prdata[7:0] = st_reg.aux;
				default: st_next.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign timerAIrq = st_reg.irqA;
	assign timerBIrq = st_reg.irqB;
	assign timerBOverflowPulse = st_reg.bOvf;
	assign timerAClkoutPin = st_reg.koA;
	assign timerBClkoutPin = st_reg.koB;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_mode0_wrap: assert property (
		stepA && !koModeA && modeA == TCC_MODE_13 && st_reg.tha == `TCC_BYTE_ONES && &st_reg.tla[4:0]
		&& !wrTla && !wrTha |=> st_reg.tha == `TCC_RST_BYTE && st_reg.tla[4:0] == 5'h00
		&& st_reg.ctrl[`TCC_CTRL_TFA])
		else $error("mode 0 wrap did not clear count or set flag");

	a_run_gate_hold: assert property (
		(!st_reg.ctrl[`TCC_CTRL_TRA] || (gateA && !timerAGatePinN)) && !splitA && !wrTla && !wrTha
		|=> $stable(st_reg.tla) && $stable(st_reg.tha))
		else $error("timer A moved while stopped or gated");

	a_mode1_wrap: assert property (
		stepA && !koModeA && modeA == TCC_MODE_16 && {st_reg.tha, st_reg.tla} == `TCC_M1_ONES
		&& !wrTla && !wrTha |=> {st_reg.tha, st_reg.tla} == 16'h0000 && st_reg.ctrl[`TCC_CTRL_TFA])
		else $error("mode 1 wrap wrong");

	a_reload_copy: assert property (
		stepA && modeA == TCC_MODE_RELOAD && st_reg.tla == `TCC_BYTE_ONES && !wrTla && !wrTha
		|=> st_reg.tla == $past(st_reg.tha) && $stable(st_reg.tha) && st_reg.ctrl[`TCC_CTRL_TFA])
		else $error("mode 2 reload wrong");

	a_b_frozen: assert property (
		frozenB && !wrTlb && !wrThb |=> $stable(st_reg.tlb) && $stable(st_reg.thb))
		else $error("timer B moved in mode 3");

	a_split_high: assert property (
		stepH && st_reg.tha == `TCC_BYTE_ONES && !wrTha |=> st_reg.tha == `TCC_RST_BYTE
		&& st_reg.ctrl[`TCC_CTRL_TFB])
		else $error("split high byte overflow did not set B flag");

	a_clkout_toggle: assert property (
		koModeA && ovfA |=> timerAClkoutPin != $past(timerAClkoutPin))
		else $error("clock output did not toggle on overflow");

	a_no_irq_clkout: assert property (
		koModeA ##1 koModeA |=> !timerAIrq)
		else $error("interrupt raised in clock-out mode");

	a_vector_clear: assert property (
		timerAVectorAck && !ovfA && !wrCtrl |=> !st_reg.ctrl[`TCC_CTRL_TFA])
		else $error("vector did not clear flag");

	a_baud_pulse: assert property (
		ovfB |=> timerBOverflowPulse ##1 !timerBOverflowPulse || $past(ovfB, 1))
		else $error("baud overflow pulse missing");

	a_split_low: assert property (
		stepA && splitA && st_reg.tla == `TCC_BYTE_ONES && !wrTla
		|=> st_reg.tla == `TCC_RST_BYTE && st_reg.ctrl[`TCC_CTRL_TFA])
		else $error("split low byte overflow wrong");

	a_slow_rate: assert property (
		!st_reg.aux[`TCC_AUX_X12A] && preTick && !wrAux |=> !rateA)
		else $error("slow rate ticked twice in a row");

	a_clkout_off_a: assert property (
		!st_reg.aux[`TCC_AUX_KOA] |=> !timerAClkoutPin)
		else $error("clock output A driven while disabled");

	a_clkout_off_b: assert property (
		!st_reg.aux[`TCC_AUX_KOB] |=> !timerBClkoutPin)
		else $error("clock output B driven while disabled");

	a_flag_set_wins: assert property (
		ovfA |=> st_reg.ctrl[`TCC_CTRL_TFA])
		else $error("overflow did not set flag A");

	a_run_off_b: assert property (
		!st_reg.ctrl[`TCC_CTRL_TRB] && !wrTlb && !wrThb |=> $stable(st_reg.tlb) && $stable(st_reg.thb))
		else $error("timer B moved with run bit clear");

	a_event_hold: assert property (
		ctA && !evIncA && !wrTla |=> $stable(st_reg.tla))
		else $error("counter moved without a detected fall");

	a_mode0_upper: assert property (
		stepA && modeA == TCC_MODE_13 && !koModeA && !wrTla |=> st_reg.tla[7:5] == $past(st_reg.tla[7:5]))
		else $error("mode 0 touched unused low-byte bits");

	a_irq_b_clkout: assert property (
		koModeB && !splitA ##1 koModeB && !splitA |=> !timerBIrq)
		else $error("interrupt B raised in clock-out mode");

	a_clkout_reload: assert property (
		stepA && koModeA && st_reg.tla == `TCC_BYTE_ONES && !wrTla && !wrTha
		|=> st_reg.tla == $past(st_reg.tha))
		else $error("clock-out reload did not copy high byte");

	a_gate_hold_b: assert property (
		gateB && !timerBGatePinN && !wrTlb && !wrThb |=> $stable(st_reg.tlb) && $stable(st_reg.thb))
		else $error("timer B moved while gated");

	a_split_b_flag: assert property (
		splitA && !ovfH && !wrCtrl && !st_reg.ctrl[`TCC_CTRL_TFB] |=> !st_reg.ctrl[`TCC_CTRL_TFB])
		else $error("timer B overflow set its flag while A is split");

	c_split_overflow: cover property (ovfH);
	c_clkout_toggle: cover property (koModeA && ovfA ##[1:300] koModeA && ovfA);
	c_event_count: cover property (ctA && evIncA && stepA);
	c_reload_b: cover property (koModeB && ovfB);
	c_gate_open: cover property (gateA && timerAGatePinN && stepA);
endmodule

// ==== tcc_regs.svh ====
// register indices, field positions and counts of the dual timer/counter
// Operation
// - mode 0: 13-bit counter, overflow flag set on all-ones to zero wrap
// - except the split high byte, count only while run bit set and gate clear or gate pin high
// - mode 1: same as mode 0 but with the full 16 bits
// - mode 2: low byte counts, overflow sets flag and reloads from high byte
// - timer B in mode 3 holds its count unchanged, except with timer select plus clock-out enable
// - timer A mode 3: low byte is its own 8-bit counter with A's controls
// - timer A mode 3: high byte times internally, uses B's run bit and flag
// - timer select plus clock-out enable: 8-bit reload, 50% duty output pin
// - clock-out overflow reloads and, except B's while A is split, sets flag, but raises no interrupt
// - timer B overflow serves baud source and clock output together
// - overflow flags set by hardware or software, cleared by software or vector
// - run bits are software written, 1 runs and 0 stops the timer
// - mode register: B in upper nibble, A in lower, gate at bits 7/3
// - select bit 6/2: 0 internal timing, 1 counts external input events
// - mode field: 13-bit, 16-bit, 8-bit reload, split or stop
// - rate bits: 0 selects clock divided by 12, 1 the full clock
// - output enable bits route each generated clock onto its pin
// - external input sampled per rate cycle, fall counts one cycle later
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

`define TCC_ADDR_W      12
`define TCC_IDX_CTRL    10'h088
`define TCC_IDX_MODE    10'h089
`define TCC_IDX_TLA     10'h08A
`define TCC_IDX_TLB     10'h08B
`define TCC_IDX_THA     10'h08C
`define TCC_IDX_THB     10'h08D
`define TCC_IDX_AUX     10'h0A3
`define TCC_RST_BYTE    8'h00
`define TCC_RST_WORD    32'h0000_0000

`define TCC_CTRL_TFB    7
`define TCC_CTRL_TRB    6
`define TCC_CTRL_TFA    5
`define TCC_CTRL_TRA    4
`define TCC_NIB_B       4
`define TCC_MODE_GATE   3
`define TCC_MODE_CT     2
`define TCC_MODE_HI     1
`define TCC_MODE_LO     0
`define TCC_AUX_X12B    3
`define TCC_AUX_X12A    2
`define TCC_AUX_KOB     1
`define TCC_AUX_KOA     0

`define TCC_PRESCALE    12
`define TCC_M0_LOW_MSB  4
`define TCC_M0_ONES     13'h1FFF
`define TCC_M1_ONES     16'hFFFF
`define TCC_BYTE_ONES   8'hFF

`endif

// ==== tcc_pkg.sv ====
// types shared by the dual timer/counter modules
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_MODE_13     = 2'h0,
		TCC_MODE_16     = 2'h1,
		TCC_MODE_RELOAD = 2'h2,
		TCC_MODE_SPLIT  = 2'h3
	} tcc_mode_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
	} tcc_pre_t;

	typedef struct packed {
		logic prev;
		logic pending;
		logic incr;
	} tcc_edge_t;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  modeSel;
		logic [7:0]  tla;
		logic [7:0]  tlb;
		logic [7:0]  tha;
		logic [7:0]  thb;
		logic [7:0]  aux;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        koA;
		logic        koB;
		logic        irqA;
		logic        irqB;
		logic        bOvf;
	} tcc_state_t;
endpackage

// ==== tcc_prescale.sv ====
// divide-by-N enable pulse for the slow timer rate
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_prescale #(
	parameter int DIV = `TCC_PRESCALE
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	output logic      tick
);
	import tcc_pkg::*;

	tcc_pre_t st_reg;
	tcc_pre_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = (st_reg.cnt == 4'(DIV - 1));
		if (st_next.tick) begin
			st_next.cnt = 4'h0;
		end else begin
			st_next.cnt = st_reg.cnt + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule

// ==== tcc_event_detect.sv ====
// samples an external count input once per rate cycle, flags falls
`timescale 1ns/1ps
module tcc_event_detect (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic sampleEn,
	input  wire logic countPin,
	output logic      incr
);
	import tcc_pkg::*;

	tcc_edge_t st_reg;
	tcc_edge_t st_next;

	// a fall seen at one sample is counted at the next sample
	always_comb begin
		st_next = st_reg;
		st_next.incr = 1'b0;
		if (sampleEn) begin
			st_next.incr = st_reg.pending;
			st_next.pending = st_reg.prev & ~countPin;
			st_next.prev = countPin;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign incr = st_reg.incr;
endmodule

// ==== tcc_pin_model.sv ====
// external count and gate pin model for the dual timer/counter
`timescale 1ns/1ps
module tcc_pin_model (
	input  wire logic core_clk,
	output logic      countPinA,
	output logic      countPinB,
	output logic      gatePinNA,
	output logic      gatePinNB
);
	// gates idle low so a gated timer stays frozen between pulses
	initial begin
		countPinA = 1'b1;
		countPinB = 1'b1;
		gatePinNA = 1'b0;
		gatePinNB = 1'b0;
	end

	// active-low pin held high for n edges opens the gate
	task automatic openGate(input logic tmr, input int n);
		gatePinNA <= !tmr;
		gatePinNB <= tmr;
		repeat (n) @(posedge core_clk);
		gatePinNA <= 1'b0;
		gatePinNB <= 1'b0;
	endtask

	// four cycles per level so full-rate sampling sees every fall
	task automatic emitFalls(input logic tmr, input int n);
		repeat (n) begin
			countPinA <= tmr ? countPinA : 1'b0;
			countPinB <= tmr ? 1'b0 : countPinB;
			repeat (4) @(posedge core_clk);
			countPinA <= 1'b1;
			countPinB <= 1'b1;
			repeat (4) @(posedge core_clk);
		end
	endtask
endmodule

// ==== dual_timer_counter_clkout_tb_top.sv ====
// self-checking bench for the dual timer/counter with clock outputs
`timescale 1ns/1ps
`include "tcc_regs.svh"
module dual_timer_counter_clkout_tb_top;
	import tcc_pkg::*;
	typedef struct packed {
		logic       tmr;
		logic       rate;
		logic [1:0] mode;
		logic [7:0] th;
		logic [7:0] tl;
		logic [7:0] cyc;
		logic [7:0] expTh;
		logic [7:0] expTl;
		logic       expFlag;
	} tcc_row_t;

	localparam logic [11:0] A_CTRL = {`TCC_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_MODE = {`TCC_IDX_MODE, 2'b00};
	localparam logic [11:0] A_TLA  = {`TCC_IDX_TLA, 2'b00};
	localparam logic [11:0] A_TLB  = {`TCC_IDX_TLB, 2'b00};
	localparam logic [11:0] A_THA  = {`TCC_IDX_THA, 2'b00};
	localparam logic [11:0] A_THB  = {`TCC_IDX_THB, 2'b00};
	localparam logic [11:0] A_AUX  = {`TCC_IDX_AUX, 2'b00};
	localparam logic [11:0] REGS [7] = '{A_CTRL, A_MODE, A_TLA, A_TLB, A_THA, A_THB, A_AUX};

	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        countPinA;
	logic        countPinB;
	logic        gatePinNA;
	logic        gatePinNB;
	logic        timerAVectorAck = 1'b0;
	logic        timerBVectorAck = 1'b0;
	logic        timerAIrq;
	logic        timerBIrq;
	logic        timerBOverflowPulse;
	logic        timerAClkoutPin;
	logic        timerBClkoutPin;
	int          n_errors = 0;
	int          n_checks = 0;
	tcc_row_t    rows [7] = '{
		'{1'b0, 1'b1, 2'h0, 8'hFF, 8'hFE, 8'h02, 8'h00, 8'hE0, 1'b1},
		'{1'b0, 1'b1, 2'h1, 8'hFF, 8'hFE, 8'h03, 8'h00, 8'h01, 1'b1},
		'{1'b0, 1'b1, 2'h2, 8'h80, 8'hFE, 8'h03, 8'h80, 8'h81, 1'b1},
		'{1'b0, 1'b0, 2'h1, 8'h12, 8'hFF, 8'h18, 8'h13, 8'h01, 1'b0},
		'{1'b1, 1'b1, 2'h0, 8'h00, 8'h1F, 8'h01, 8'h01, 8'h00, 1'b0},
		'{1'b1, 1'b1, 2'h2, 8'h05, 8'hFF, 8'h02, 8'h05, 8'h06, 1'b1},
		'{1'b1, 1'b0, 2'h2, 8'h00, 8'h10, 8'h24, 8'h00, 8'h13, 1'b0}};

	always #10 core_clk = ~core_clk;

	tcc_pin_model tcc_pin_model_i (.core_clk(core_clk), .countPinA(countPinA), .countPinB(countPinB),
		.gatePinNA(gatePinNA), .gatePinNB(gatePinNB));

	tcc_dual_timer tcc_dual_timer_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timerACountPin(countPinA), .timerBCountPin(countPinB), .timerAGatePinN(gatePinNA),
		.timerBGatePinN(gatePinNB), .timerAVectorAck(timerAVectorAck), .timerBVectorAck(timerBVectorAck),
		.timerAIrq(timerAIrq), .timerBIrq(timerBIrq), .timerBOverflowPulse(timerBOverflowPulse),
		.timerAClkoutPin(timerAClkoutPin), .timerBClkoutPin(timerBClkoutPin));

	task automatic conclude();
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// pready and read data are taken at the rising edge, before the design updates them
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic err);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_errors++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 8'h00, rd, err);
		check(rd, {24'h0, e});
	endtask

	task automatic pins(input logic [1:0] e);
		@(negedge core_clk);
		check({30'h0, timerAClkoutPin, timerBClkoutPin}, {30'h0, e});
		@(posedge core_clk);
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		conclude();
	end

	initial begin
		tcc_row_t    r;
		logic [31:0] rd;
		logic        err;
		int          hiA;
		int          hiB;
		int          ovB;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		pins(2'b00);
		foreach (REGS[i]) rdc(REGS[i], `TCC_RST_BYTE);
		wr(A_MODE, 8'hA5);
		rdc(A_MODE, 8'hA5);
		wr(A_AUX, 8'hF0);
		rdc(A_AUX, 8'hF0);
		wr(A_CTRL, 8'hAF);
		@(negedge core_clk);
		check({30'h0, timerAIrq, timerBIrq}, 32'h3);
		@(posedge core_clk);
		timerAVectorAck <= 1'b1;
		timerBVectorAck <= 1'b1;
		@(posedge core_clk);
		timerAVectorAck <= 1'b0;
		timerBVectorAck <= 1'b0;
		rdc(A_CTRL, 8'h0F);
		apb(1'b0, 12'h3FC, 8'h00, rd, err);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		// gate bit set so only the model's pulse width lets the count step
		foreach (rows[i]) begin
			r = rows[i];
			wr(A_AUX, {4'h0, r.rate, r.rate, 2'b00});
			wr(A_MODE, r.tmr ? {2'b10, r.mode, 4'h0} : {4'h0, 2'b10, r.mode});
			wr(r.tmr ? A_THB : A_THA, r.th);
			wr(r.tmr ? A_TLB : A_TLA, r.tl);
			wr(A_CTRL, r.tmr ? 8'h40 : 8'h10);
			tcc_pin_model_i.openGate(r.tmr, int'(r.cyc));
			repeat (4) @(posedge core_clk);
			rdc(r.tmr ? A_TLB : A_TLA, r.expTl);
			rdc(r.tmr ? A_THB : A_THA, r.expTh);
			rdc(A_CTRL, r.tmr ? {r.expFlag, 7'h40} : {2'b00, r.expFlag, 5'h10});
			wr(A_CTRL, 8'h00);
		end
		wr(A_AUX, 8'h04);
		wr(A_MODE, 8'h05);
		wr(A_TLA, 8'h00);
		wr(A_CTRL, 8'h10);
		tcc_pin_model_i.emitFalls(1'b0, 3);
		rdc(A_TLA, 8'h03);
		wr(A_CTRL, 8'h00);
		tcc_pin_model_i.emitFalls(1'b0, 2);
		rdc(A_TLA, 8'h03);
		wr(A_MODE, 8'h30);
		wr(A_AUX, 8'h08);
		wr(A_TLB, 8'h44);
		wr(A_CTRL, 8'h40);
		repeat (30) @(posedge core_clk);
		rdc(A_TLB, 8'h44);
		// stop B first so the split high byte only starts with the run write
		wr(A_CTRL, 8'h00);
		wr(A_MODE, 8'h03);
		wr(A_AUX, 8'h04);
		wr(A_THA, 8'hFE);
		wr(A_TLA, 8'h00);
		wr(A_CTRL, 8'h40);
		repeat (20) @(posedge core_clk);
		rdc(A_CTRL, 8'hC0);
		rdc(A_TLA, 8'h00);
		wr(A_MODE, 8'h0B);
		wr(A_TLA, 8'hFF);
		wr(A_CTRL, 8'h10);
		tcc_pin_model_i.openGate(1'b0, 1);
		repeat (3) @(posedge core_clk);
		rdc(A_CTRL, 8'h30);
		rdc(A_TLA, 8'h00);
		// software setup order for clock output on both timers, reload before start
		wr(A_CTRL, 8'h00);
		wr(A_AUX, 8'h0F);
		wr(A_MODE, 8'h00);
		wr(A_THA, 8'hFE);
		wr(A_THB, 8'hFE);
		wr(A_TLA, 8'hFE);
		wr(A_TLB, 8'hFE);
		wr(A_CTRL, 8'h50);
		repeat (8) @(posedge core_clk);
		hiA = 0;
		hiB = 0;
		ovB = 0;
		repeat (40) begin
			@(negedge core_clk);
			hiA += (timerAClkoutPin === 1'b1);
			hiB += (timerBClkoutPin === 1'b1);
			ovB += (timerBOverflowPulse === 1'b1);
			check({30'h0, timerAIrq, timerBIrq}, 32'h0);
		end
		@(posedge core_clk);
		check(32'(hiA), 32'd20);
		check(32'(hiB), 32'd20);
		check(32'(ovB), 32'd20);
		rdc(A_CTRL, 8'hF0);
		wr(A_AUX, 8'h0C);
		repeat (3) @(posedge core_clk);
		pins(2'b00);
		conclude();
	end
endmodule
